// ---- shared/hlrfe_pkg.sv ----
// Package of constants and types for the host link register front end
package hlrfe_pkg;

  // ----------------------------------------------------------------
  // Configuration space offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_BAR_OFS       = 8'h10;
  localparam logic [7:0]  CFG_ALIAS_OFS     = 8'hF8;
  localparam logic [7:0]  CFG_LINK_ENH_OFS  = 8'hD4;
  localparam logic [31:0] ALIAS_RESET       = 32'h0000_0000;
  localparam logic [31:0] BAR_RESET         = 32'h0000_0000;
  localparam logic [31:0] BAR_ADDR_MASK     = 32'hFFFF_F800;

  // ----------------------------------------------------------------
  // Memory map, 2K-byte window
  // ----------------------------------------------------------------
  localparam int          MEM_ADDR_W        = 11;
  localparam logic [10:0] OFS_VERSION       = 11'h000;
  localparam logic [10:0] OFS_ROM_ACCESS    = 11'h004;
  localparam logic [10:0] OFS_RETRY_LIMITS  = 11'h008;
  localparam logic [10:0] OFS_LOCK_DATA     = 11'h00C;
  localparam logic [10:0] OFS_LOCK_CMP      = 11'h010;
  localparam logic [10:0] OFS_LOCK_CTRL     = 11'h014;
  localparam logic [10:0] OFS_ROM_HEADER    = 11'h018;
  localparam logic [10:0] OFS_BUS_NAME      = 11'h01C;
  localparam logic [10:0] OFS_BUS_OPTION    = 11'h020;
  localparam logic [10:0] OFS_UID_UPPER     = 11'h024;
  localparam logic [10:0] OFS_UID_LOWER     = 11'h028;
  localparam logic [10:0] OFS_ROM_BASE      = 11'h034;
  localparam logic [10:0] OFS_POST_LO       = 11'h038;
  localparam logic [10:0] OFS_POST_HI       = 11'h03C;
  localparam logic [10:0] OFS_MAKER_ID      = 11'h040;
  localparam logic [10:0] OFS_HC_SET        = 11'h050;
  localparam logic [10:0] OFS_HC_CLR        = 11'h054;
  localparam logic [10:0] OFS_NODE_BUF      = 11'h064;
  localparam logic [10:0] OFS_NODE_COUNT    = 11'h068;
  localparam logic [10:0] OFS_CHHI_SET      = 11'h070;
  localparam logic [10:0] OFS_CHHI_CLR      = 11'h074;
  localparam logic [10:0] OFS_CHLO_SET      = 11'h078;
  localparam logic [10:0] OFS_CHLO_CLR      = 11'h07C;

  // Plain storage words kept in the small memory
  localparam int          STORE_DEPTH       = 8;
  localparam int          STORE_AW          = 3;

  // ----------------------------------------------------------------
  // Link enhancement control fields
  // ----------------------------------------------------------------
  localparam int          LEC_MPEG_BIT      = 10;
  localparam int          LEC_DV_BIT        = 8;
  localparam int          LEC_PRIO_BIT      = 7;
  localparam int          LEC_RSVD2_BIT     = 2;
  localparam int          LEC_ACCEL_BIT     = 1;
  localparam int          LEC_THR_LSB       = 12;
  localparam logic [31:0] LEC_WR_MASK       = 32'h0000_F586;
  localparam logic [31:0] LEC_RESET         = 32'h0000_0000;
  localparam logic [7:0]  FMT_MPEG          = 8'h20;
  localparam logic [7:0]  FMT_DV            = 8'h00;

  // Transmit threshold encodings
  typedef enum logic [1:0] {
    HLRFE_THR_4K   = 2'h0,
    HLRFE_THR_1K7  = 2'h1,
    HLRFE_THR_1K   = 2'h2,
    HLRFE_THR_512  = 2'h3
  } hlrfe_thr_e;

  // ----------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hlrfe_req_s;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] rdata;
  } hlrfe_rsp_s;

endpackage : hlrfe_pkg

// ---- src/hlrfe_store.sv ----
// Small word store for the plain read/write host link registers
`timescale 1ns/1ns
module hlrfe_store (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Write port
  input  wire logic                          we,
  input  wire logic [hlrfe_pkg::STORE_AW-1:0] waddr,
  input  wire logic [31:0]                   wdata,
  // Read port, registered data
  input  wire logic [hlrfe_pkg::STORE_AW-1:0] raddr,
  output logic      [31:0]                   rdata
);

  // Storage array
  logic [31:0] mem_reg [hlrfe_pkg::STORE_DEPTH];

  // Writes land on the clock edge after the request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < hlrfe_pkg::STORE_DEPTH; i++)
        mem_reg[i] <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      if (we)
        mem_reg[waddr] <= wdata;
      rdata <= mem_reg[raddr];
    end
  end

endmodule : hlrfe_store

// ---- src/hlrfe_setclr.sv ----
// One set/clear register pair with masked read option
`timescale 1ns/1ns
module hlrfe_setclr (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Write strobes and data
  input  wire logic        set_we,
  input  wire logic        clr_we,
  input  wire logic [31:0] wdata,
  // Companion mask for masked reads
  input  wire logic [31:0] mask,
  // Shared contents and masked view
  output logic      [31:0] value,
  output logic      [31:0] masked
);

  logic [31:0] value_reg;
  logic [31:0] value_next;

  // Ones at set address set, ones at clear address clear
  assign value_next = set_we ? (value_reg | wdata) :
                      clr_we ? (value_reg & ~wdata) : value_reg;
  assign value      = value_reg;
  assign masked     = value_reg & mask;

  // Shared register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      value_reg <= 32'h0000_0000;
    else
      value_reg <= value_next;
  end

endmodule : hlrfe_setclr

// ---- src/hlrfe_top.sv ----
// Register front end of the host link controller
`timescale 1ns/1ns
module hlrfe_top (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST,
  // Configuration space access
  input  wire hlrfe_pkg::hlrfe_req_s CFG_REQ,
  output hlrfe_pkg::hlrfe_rsp_s      CFG_RSP,
  // Memory space access
  input  wire hlrfe_pkg::hlrfe_req_s MEM_REQ,
  output hlrfe_pkg::hlrfe_rsp_s      MEM_RSP,
  // Read-only values from the link core
  input  wire logic [31:0]           VERSION_IN,
  input  wire logic [31:0]           BUS_NAME_IN,
  input  wire logic [31:0]           UID_UPPER_IN,
  input  wire logic [31:0]           UID_LOWER_IN,
  input  wire logic [31:0]           POST_LO_IN,
  input  wire logic [31:0]           POST_HI_IN,
  input  wire logic [31:0]           MAKER_ID_IN,
  input  wire logic [31:0]           NODE_COUNT_IN,
  // Transmit stream format code
  input  wire logic [7:0]            STREAM_FORMAT_CODE,
  // Controls to the link core
  output logic                       TIMESTAMP_ENH_ACTIVE,
  output logic                       PRIORITY_ARB_EN,
  output logic                       PHY_ACCEL_SUPPORT,
  output logic [1:0]                 TX_THRESHOLD,
  output logic                       CORE_RSVD_CTRL,
  output logic [31:0]                SUBSYSTEM_ID,
  output logic [31:0]                HOST_CTRL,
  output logic [31:0]                CHAN_MASK_HI,
  output logic [31:0]                CHAN_MASK_LO
);

  // ----------------------------------------------------------------
  // Configuration space registers
  // ----------------------------------------------------------------

  logic [31:0] lec_reg;         // Link enhancement control
  logic [31:0] lec_next;
  logic [31:0] alias_reg;       // Subsystem alias
  logic [31:0] alias_next;
  logic [31:0] bar_reg;         // Memory base address
  logic [31:0] bar_next;
  logic [31:0] cfg_rdata_reg;   // Registered config read data
  logic [31:0] cfg_rdata_next;
  logic        cfg_valid_reg;   // Config answer strobe
  logic        cfg_hit_reg;     // Config answer hit flag
  logic        cfg_hit_next;

  // Config decode
  wire logic [7:0] cfg_ofs   = CFG_REQ.addr[7:0];
  wire logic       cfg_wr    = CFG_REQ.valid & CFG_REQ.write;
  wire logic       cfg_lec   = (cfg_ofs == hlrfe_pkg::CFG_LINK_ENH_OFS);
  wire logic       cfg_alias = (cfg_ofs == hlrfe_pkg::CFG_ALIAS_OFS);
  wire logic       cfg_bar   = (cfg_ofs == hlrfe_pkg::CFG_BAR_OFS);

  // Only writable bits take new values; reserved read-only bits stay zero
  assign lec_next   = (cfg_wr & cfg_lec) ?
                      (CFG_REQ.wdata & hlrfe_pkg::LEC_WR_MASK) : lec_reg;
  assign alias_next = (cfg_wr & cfg_alias) ? CFG_REQ.wdata : alias_reg;
  assign bar_next   = (cfg_wr & cfg_bar) ?
                      (CFG_REQ.wdata & hlrfe_pkg::BAR_ADDR_MASK) : bar_reg;

  // Config read mux
  assign cfg_rdata_next = cfg_lec   ? lec_reg   :
                          cfg_alias ? alias_reg :
                          cfg_bar   ? bar_reg   : 32'h0000_0000;
  assign cfg_hit_next   = cfg_lec | cfg_alias | cfg_bar;

  // Config registers update one edge after the request
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      lec_reg       <= hlrfe_pkg::LEC_RESET;
      alias_reg     <= hlrfe_pkg::ALIAS_RESET;
      bar_reg       <= hlrfe_pkg::BAR_RESET;
      cfg_rdata_reg <= 32'h0000_0000;
      cfg_valid_reg <= 1'b0;
      cfg_hit_reg   <= 1'b0;
    end
    else
    begin
      lec_reg       <= lec_next;
      alias_reg     <= alias_next;
      bar_reg       <= bar_next;
      cfg_rdata_reg <= cfg_rdata_next;
      cfg_valid_reg <= CFG_REQ.valid;
      cfg_hit_reg   <= cfg_hit_next;
    end
  end

  // Config answer
  assign CFG_RSP = '{valid: cfg_valid_reg, hit: cfg_hit_reg, rdata: cfg_rdata_reg};

  // ----------------------------------------------------------------
  // Link enhancement control outputs
  // ----------------------------------------------------------------

  wire logic mpeg_on = lec_reg[hlrfe_pkg::LEC_MPEG_BIT] &
                       (STREAM_FORMAT_CODE == hlrfe_pkg::FMT_MPEG);
  wire logic dv_on   = lec_reg[hlrfe_pkg::LEC_DV_BIT] &
                       (STREAM_FORMAT_CODE == hlrfe_pkg::FMT_DV);

  // Timestamp enhancement applies only to the matching stream format
  assign TIMESTAMP_ENH_ACTIVE = mpeg_on | dv_on;
  assign PRIORITY_ARB_EN      = lec_reg[hlrfe_pkg::LEC_PRIO_BIT];
  assign PHY_ACCEL_SUPPORT    = lec_reg[hlrfe_pkg::LEC_ACCEL_BIT];
  assign TX_THRESHOLD         = lec_reg[hlrfe_pkg::LEC_THR_LSB +: 2];
  // Passed through untouched; software is expected to keep it zero
  assign CORE_RSVD_CTRL       = lec_reg[hlrfe_pkg::LEC_RSVD2_BIT];
  assign SUBSYSTEM_ID         = alias_reg;

  // ----------------------------------------------------------------
  // Memory space decode
  // ----------------------------------------------------------------

  // Window hit against the base address
  wire logic        mem_in_win = MEM_REQ.valid &
    ((MEM_REQ.addr & hlrfe_pkg::BAR_ADDR_MASK) == bar_reg);
  wire logic [10:0] mem_ofs    = MEM_REQ.addr[hlrfe_pkg::MEM_ADDR_W-1:0];
  wire logic        mem_wr     = mem_in_win & MEM_REQ.write;

  // Pair strobes
  wire logic hc_set_we   = mem_wr & (mem_ofs == hlrfe_pkg::OFS_HC_SET);
  wire logic hc_clr_we   = mem_wr & (mem_ofs == hlrfe_pkg::OFS_HC_CLR);
  wire logic chhi_set_we = mem_wr & (mem_ofs == hlrfe_pkg::OFS_CHHI_SET);
  wire logic chhi_clr_we = mem_wr & (mem_ofs == hlrfe_pkg::OFS_CHHI_CLR);
  wire logic chlo_set_we = mem_wr & (mem_ofs == hlrfe_pkg::OFS_CHLO_SET);
  wire logic chlo_clr_we = mem_wr & (mem_ofs == hlrfe_pkg::OFS_CHLO_CLR);

  // Map a writable plain register offset onto a store index
  function automatic logic [hlrfe_pkg::STORE_AW:0] store_index(input logic [10:0] ofs);
    case (ofs)
      hlrfe_pkg::OFS_ROM_ACCESS:   store_index = 4'h8;
      hlrfe_pkg::OFS_RETRY_LIMITS: store_index = 4'h9;
      hlrfe_pkg::OFS_LOCK_DATA:    store_index = 4'hA;
      hlrfe_pkg::OFS_LOCK_CMP:     store_index = 4'hB;
      hlrfe_pkg::OFS_LOCK_CTRL:    store_index = 4'hC;
      hlrfe_pkg::OFS_ROM_HEADER:   store_index = 4'hD;
      hlrfe_pkg::OFS_BUS_OPTION:   store_index = 4'hE;
      hlrfe_pkg::OFS_ROM_BASE:     store_index = 4'hF;
      default:                     store_index = 4'h0;
    endcase
  endfunction : store_index

  // Node buffer pointer lives in its own register, kept out of the store
  wire logic [3:0] st_idx  = (mem_ofs == hlrfe_pkg::OFS_NODE_BUF) ? 4'h8 :
                             store_index(mem_ofs);
  wire logic       st_node = (mem_ofs == hlrfe_pkg::OFS_NODE_BUF);
  wire logic       st_hit  = st_idx[3] & ~st_node;

  // ----------------------------------------------------------------
  // Pair and store instances
  // ----------------------------------------------------------------

  logic [31:0] hc_val;
  logic [31:0] chhi_val;
  logic [31:0] chlo_val;
  logic [31:0] hc_msk;           // Clear-address read views
  logic [31:0] chhi_msk;
  logic [31:0] chlo_msk;
  logic [31:0] store_rdata;
  logic [31:0] node_buf_reg;     // Node report buffer pointer
  logic [31:0] node_buf_next;

  // Host controller pair
  hlrfe_setclr u_hc (
    .clk    (CLK),
    .rst    (RST),
    .set_we (hc_set_we),
    .clr_we (hc_clr_we),
    .wdata  (MEM_REQ.wdata),
    .mask   (32'hFFFF_FFFF),
    .value  (hc_val),
    .masked (hc_msk)
  );

  // Channel mask high pair
  hlrfe_setclr u_chhi (
    .clk    (CLK),
    .rst    (RST),
    .set_we (chhi_set_we),
    .clr_we (chhi_clr_we),
    .wdata  (MEM_REQ.wdata),
    .mask   (32'hFFFF_FFFF),
    .value  (chhi_val),
    .masked (chhi_msk)
  );

  // Channel mask low pair
  hlrfe_setclr u_chlo (
    .clk    (CLK),
    .rst    (RST),
    .set_we (chlo_set_we),
    .clr_we (chlo_clr_we),
    .wdata  (MEM_REQ.wdata),
    .mask   (32'hFFFF_FFFF),
    .value  (chlo_val),
    .masked (chlo_msk)
  );

  // Plain read/write words
  hlrfe_store u_store (
    .clk   (CLK),
    .rst   (RST),
    .we    (mem_wr & st_hit),
    .waddr (st_idx[2:0]),
    .wdata (MEM_REQ.wdata),
    .raddr (st_idx[2:0]),
    .rdata (store_rdata)
  );

  assign node_buf_next = (mem_wr & st_node) ? MEM_REQ.wdata : node_buf_reg;

  // ----------------------------------------------------------------
  // Memory read path
  // ----------------------------------------------------------------

  logic [31:0] mem_rdata_reg;   // Registered direct read data
  logic [31:0] mem_rdata_next;
  logic        mem_valid_reg;   // Memory answer strobe
  logic        mem_hit_reg;     // Access fell inside the window
  logic        mem_st_reg;      // Answer comes from the store

  // Direct read mux; reserved and unknown offsets read zero
  assign mem_rdata_next =
    (mem_ofs == hlrfe_pkg::OFS_VERSION)    ? VERSION_IN    :
    (mem_ofs == hlrfe_pkg::OFS_BUS_NAME)   ? BUS_NAME_IN   :
    (mem_ofs == hlrfe_pkg::OFS_UID_UPPER)  ? UID_UPPER_IN  :
    (mem_ofs == hlrfe_pkg::OFS_UID_LOWER)  ? UID_LOWER_IN  :
    (mem_ofs == hlrfe_pkg::OFS_POST_LO)    ? POST_LO_IN    :
    (mem_ofs == hlrfe_pkg::OFS_POST_HI)    ? POST_HI_IN    :
    (mem_ofs == hlrfe_pkg::OFS_MAKER_ID)   ? MAKER_ID_IN   :
    (mem_ofs == hlrfe_pkg::OFS_NODE_COUNT) ? NODE_COUNT_IN :
    (mem_ofs == hlrfe_pkg::OFS_NODE_BUF)   ? node_buf_reg  :
    // Clear addresses read the masked view; these pairs use an open mask
    (mem_ofs == hlrfe_pkg::OFS_HC_SET)     ? hc_val        :
    (mem_ofs == hlrfe_pkg::OFS_HC_CLR)     ? hc_msk        :
    (mem_ofs == hlrfe_pkg::OFS_CHHI_SET)   ? chhi_val      :
    (mem_ofs == hlrfe_pkg::OFS_CHHI_CLR)   ? chhi_msk      :
    (mem_ofs == hlrfe_pkg::OFS_CHLO_SET)   ? chlo_val      :
    (mem_ofs == hlrfe_pkg::OFS_CHLO_CLR)   ? chlo_msk      :
    32'h0000_0000;

  // Answer one edge after the request
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mem_rdata_reg <= 32'h0000_0000;
      mem_valid_reg <= 1'b0;
      mem_hit_reg   <= 1'b0;
      mem_st_reg    <= 1'b0;
      node_buf_reg  <= 32'h0000_0000;
    end
    else
    begin
      mem_rdata_reg <= mem_rdata_next;
      mem_valid_reg <= MEM_REQ.valid;
      mem_hit_reg   <= mem_in_win;
      mem_st_reg    <= st_hit;
      node_buf_reg  <= node_buf_next;
    end
  end

  assign MEM_RSP = '{valid: mem_valid_reg, hit: mem_hit_reg,
                     rdata: mem_hit_reg ? (mem_st_reg ? store_rdata : mem_rdata_reg)
                                        : 32'h0000_0000};

  // Pair contents to the link core
  assign HOST_CTRL    = hc_val;
  assign CHAN_MASK_HI = chhi_val;
  assign CHAN_MASK_LO = chlo_val;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  lec_rsvd_zero_a : assert property (@(posedge CLK) disable iff (RST)
    (lec_reg & ~hlrfe_pkg::LEC_WR_MASK) == 32'h0000_0000)
    else $error("reserved link control bits not zero");

  mpeg_gate_a : assert property (@(posedge CLK) disable iff (RST)
    (lec_reg[hlrfe_pkg::LEC_MPEG_BIT] && STREAM_FORMAT_CODE == hlrfe_pkg::FMT_MPEG)
    |-> TIMESTAMP_ENH_ACTIVE)
    else $error("mpeg enhancement not active");

  dv_gate_a : assert property (@(posedge CLK) disable iff (RST)
    (!lec_reg[hlrfe_pkg::LEC_MPEG_BIT] && !lec_reg[hlrfe_pkg::LEC_DV_BIT])
    |-> !TIMESTAMP_ENH_ACTIVE)
    else $error("enhancement active while disabled");

  prio_write_a : assert property (@(posedge CLK) disable iff (RST)
    (cfg_wr && cfg_lec) |=> PRIORITY_ARB_EN == $past(CFG_REQ.wdata[7]))
    else $error("priority enable not written");

  accel_write_a : assert property (@(posedge CLK) disable iff (RST)
    (cfg_wr && cfg_lec) |=> PHY_ACCEL_SUPPORT == $past(CFG_REQ.wdata[1]))
    else $error("accel enable not written");

  alias_readback_a : assert property (@(posedge CLK) disable iff (RST)
    (cfg_wr && cfg_alias) ##1 !CFG_REQ.valid ##1
    (CFG_REQ.valid && !CFG_REQ.write && cfg_alias)
    |=> CFG_RSP.rdata == $past(CFG_REQ.wdata, 3))
    else $error("alias read back wrong");

  pair_set_a : assert property (@(posedge CLK) disable iff (RST)
    hc_set_we |=> (HOST_CTRL & $past(MEM_REQ.wdata)) == $past(MEM_REQ.wdata))
    else $error("set address did not set bits");

  pair_clear_a : assert property (@(posedge CLK) disable iff (RST)
    chlo_clr_we |=> (CHAN_MASK_LO & $past(MEM_REQ.wdata)) == 32'h0000_0000)
    else $error("clear address did not clear bits");

  answer_time_a : assert property (@(posedge CLK) disable iff (RST)
    MEM_REQ.valid |=> MEM_RSP.valid)
    else $error("memory answer late");

  cfg_answer_a : assert property (@(posedge CLK) disable iff (RST)
    CFG_REQ.valid |=> CFG_RSP.valid)
    else $error("config answer late");

  dv_on_a : assert property (@(posedge CLK) disable iff (RST)
    (lec_reg[hlrfe_pkg::LEC_DV_BIT] && STREAM_FORMAT_CODE == hlrfe_pkg::FMT_DV)
    |-> TIMESTAMP_ENH_ACTIVE)
    else $error("dv enhancement not active");

  alias_update_a : assert property (@(posedge CLK) disable iff (RST)
    (cfg_wr && cfg_alias) |=> SUBSYSTEM_ID == $past(CFG_REQ.wdata))
    else $error("alias write did not reach subsystem id");

  thr_write_a : assert property (@(posedge CLK) disable iff (RST)
    (cfg_wr && cfg_lec) |=> TX_THRESHOLD == $past(CFG_REQ.wdata[hlrfe_pkg::LEC_THR_LSB +: 2]))
    else $error("threshold field not written");

  pair_read_a : assert property (@(posedge CLK) disable iff (RST)
    (mem_in_win && !MEM_REQ.write && mem_ofs == hlrfe_pkg::OFS_CHHI_SET)
    |=> MEM_RSP.rdata == $past(CHAN_MASK_HI))
    else $error("pair read wrong");

  rsvd_read_a : assert property (@(posedge CLK) disable iff (RST)
    (mem_in_win && mem_ofs >= 11'h044 && mem_ofs <= 11'h04C)
    |=> MEM_RSP.rdata == 32'h0000_0000)
    else $error("reserved offset read not zero");

  window_miss_a : assert property (@(posedge CLK) disable iff (RST)
    (MEM_REQ.valid && !mem_in_win) |=> (!MEM_RSP.hit && MEM_RSP.rdata == 32'h0000_0000))
    else $error("access outside window answered");

endmodule : hlrfe_top

// ---- testbench/hlrfe_host.sv ----
// Host software model issuing configuration and memory word accesses
`timescale 1ns/1ns
module hlrfe_host (
  // Clock
  input  wire logic                  clk,
  // Requests out
  output hlrfe_pkg::hlrfe_req_s      cfg_req,
  output hlrfe_pkg::hlrfe_req_s      mem_req,
  // Answers in
  input  wire hlrfe_pkg::hlrfe_rsp_s cfg_rsp,
  input  wire hlrfe_pkg::hlrfe_rsp_s mem_rsp
);
  // Idle buses at time zero
  initial
  begin
    cfg_req = '0;
    mem_req = '0;
  end

  // One word access, taken at the next edge, answer sampled one cycle later
  task automatic access(input logic sp, input logic wr, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q, output logic h);
    hlrfe_pkg::hlrfe_req_s r;
    begin
      // Software keeps the writable reserved control bit at zero
      if (sp && a[7:0] == hlrfe_pkg::CFG_LINK_ENH_OFS)
        d[hlrfe_pkg::LEC_RSVD2_BIT] = 1'b0;
      r = '{valid: 1'b1, write: wr, addr: a, wdata: d};
      @(posedge clk);
      if (sp) cfg_req <= r;
      else mem_req <= r;
      @(posedge clk);
      // Released request shows inverted leftovers, never the last value
      if (sp) cfg_req <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
      else mem_req <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
      #1;
      q = sp ? cfg_rsp.rdata : mem_rsp.rdata;
      h = sp ? cfg_rsp.hit : mem_rsp.hit;
    end
  endtask : access
endmodule : hlrfe_host

// ---- testbench/hlrfe_top_bench.sv ----
// Self-checking bench for the host link register front end
`timescale 1ns/1ns
module hlrfe_top_bench;
  logic                  clk;      // Core clock
  logic                  rst;      // Reset, active high
  hlrfe_pkg::hlrfe_req_s cfg_req;  // Config request
  hlrfe_pkg::hlrfe_req_s mem_req;  // Memory request
  hlrfe_pkg::hlrfe_rsp_s cfg_rsp;  // Config answer
  hlrfe_pkg::hlrfe_rsp_s mem_rsp;  // Memory answer
  logic [31:0]           ro [8];   // Read-only source words
  logic [7:0]            fmt;      // Stream format code
  logic                  ts, prio, accel, rsvd;
  logic [1:0]            thr;
  logic [31:0]           sub_id, hc, chi, clo, q;
  logic                  h;
  int                    err_total, checks;
  logic [10:0] ro_ofs [8] = '{11'h00, 11'h1C, 11'h24, 11'h28, 11'h38, 11'h3C, 11'h40, 11'h68};
  logic [10:0] rsv_ofs [9] = '{11'h2C, 11'h30, 11'h44, 11'h48, 11'h4C, 11'h58, 11'h5C,
                               11'h60, 11'h6C};
  logic [10:0] pr [3] = '{11'h50, 11'h70, 11'h78};

  hlrfe_top hlrfe_top_i (.CLK(clk), .RST(rst), .CFG_REQ(cfg_req), .CFG_RSP(cfg_rsp),
    .MEM_REQ(mem_req), .MEM_RSP(mem_rsp), .VERSION_IN(ro[0]), .BUS_NAME_IN(ro[1]),
    .UID_UPPER_IN(ro[2]), .UID_LOWER_IN(ro[3]), .POST_LO_IN(ro[4]), .POST_HI_IN(ro[5]),
    .MAKER_ID_IN(ro[6]), .NODE_COUNT_IN(ro[7]), .STREAM_FORMAT_CODE(fmt),
    .TIMESTAMP_ENH_ACTIVE(ts), .PRIORITY_ARB_EN(prio), .PHY_ACCEL_SUPPORT(accel),
    .TX_THRESHOLD(thr), .CORE_RSVD_CTRL(rsvd), .SUBSYSTEM_ID(sub_id), .HOST_CTRL(hc),
    .CHAN_MASK_HI(chi), .CHAN_MASK_LO(clo));
  hlrfe_host hlrfe_host_i (.clk(clk), .cfg_req(cfg_req), .mem_req(mem_req),
    .cfg_rsp(cfg_rsp), .mem_rsp(mem_rsp));

  // ----------------------------------------------------------------
  // Compare, access and verdict tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic sp, input logic [31:0] a, input logic [31:0] d);
    hlrfe_host_i.access(sp, 1'b1, a, d, q, h);
  endtask : wr

  // Read and compare data, hit flag and answer strobe
  task automatic rd(input logic sp, input logic [31:0] a, input logic [31:0] e,
                    input logic eh);
    hlrfe_host_i.access(sp, 1'b0, a, 32'h0, q, h);
    cmp(q, e);
    cmp({31'h0, h}, {31'h0, eh});
    cmp({31'h0, (sp ? cfg_rsp.valid : mem_rsp.valid)}, 32'h1);
  endtask : rd

  task automatic summarize;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Free-running 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    #50000;
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    fmt = 8'h00;
    foreach (ro[i]) ro[i] = 32'h1357_0000 + 32'(i * 5 + 1);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(1'b1, 32'hF8, 32'h0, 1'b1);
    rd(1'b1, 32'hD4, 32'h0, 1'b1);
    wr(1'b1, 32'hF8, 32'h1234_ABCD);
    cmp(sub_id, 32'h1234_ABCD);
    rd(1'b1, 32'hF8, 32'h1234_ABCD, 1'b1);
    $display("test alias done");
    // All ones except the reserved bit; read-only holes read zero
    wr(1'b1, 32'hD4, 32'hFFFF_FFFF);
    rd(1'b1, 32'hD4, 32'h0000_F582, 1'b1);
    cmp({29'h0, prio, accel, rsvd}, 32'h6);
    for (int t = 0; t < 4; t++)
    begin
      wr(1'b1, 32'hD4, 32'(t) << 12);
      cmp({30'h0, thr}, 32'(t));
    end
    // Mpeg and dv enables against both format codes
    for (int k = 0; k < 4; k++)
    begin
      wr(1'b1, 32'hD4, k[1] ? 32'h400 : 32'h100);
      @(posedge clk);
      fmt <= k[0] ? 8'h20 : 8'h00;
      @(posedge clk);
      #1;
      cmp({31'h0, ts}, {31'h0, k[1] == k[0]});
    end
    $display("test link control done");
    for (int p = 0; p < 3; p++)
    begin
      wr(1'b0, 32'(pr[p]), 32'hA5A5_0F0F);
      wr(1'b0, 32'(pr[p]), 32'h0000_F000);
      wr(1'b0, 32'(pr[p]) + 32'h4, 32'h0000_0F0F);
      rd(1'b0, 32'(pr[p]), 32'hA5A5_F000, 1'b1);
      rd(1'b0, 32'(pr[p]) + 32'h4, 32'hA5A5_F000, 1'b1);
      cmp(p == 0 ? hc : p == 1 ? chi : clo, 32'hA5A5_F000);
      wr(1'b0, 32'(pr[p]) + 32'h4, 32'hFFFF_FFFF);
      cmp(p == 0 ? hc : p == 1 ? chi : clo, 32'h0);
    end
    $display("test set clear done");
    foreach (rsv_ofs[i])
    begin
      wr(1'b0, 32'(rsv_ofs[i]), 32'hFFFF_FFFF);
      rd(1'b0, 32'(rsv_ofs[i]), 32'h0, 1'b1);
    end
    foreach (ro_ofs[i])
    begin
      wr(1'b0, 32'(ro_ofs[i]), 32'hDEAD_BEEF);
      rd(1'b0, 32'(ro_ofs[i]), ro[i], 1'b1);
    end
    $display("test map done");
    wr(1'b0, 32'h08, 32'h0000_0F5A);
    wr(1'b0, 32'h808, 32'hFFFF_FFFF);
    wr(1'b0, 32'h64, 32'h0000_0C40);
    rd(1'b0, 32'h64, 32'h0000_0C40, 1'b1);
    rd(1'b0, 32'h800, 32'h0, 1'b0);
    rd(1'b1, 32'hF4, 32'h0, 1'b0);
    wr(1'b1, 32'h10, 32'h0001_0000);
    rd(1'b0, 32'h0001_0008, 32'h0000_0F5A, 1'b1);
    rd(1'b0, 32'h08, 32'h0, 1'b0);
    $display("test window done");
    summarize();
  end
endmodule : hlrfe_top_bench
